// ### gpcc_port.sv
// gpcc_port.sv: 8-pin general purpose port with constant-current drive
// assumes an apb master on the system clock and pad levels already synchronous
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "gpcc_cfg.svh"

// Function
// [RL1] global enable limits current on enabled pins
// [RL2] select field codes 1, 2, 5, 10 mA
// [RL3] software sets pin enables only when global set
// [RL4] pin cc active needs pin and global enable
// [RL5] eight independent bidirectional pins
// [RL6] direction one disables driver, zero drives latch
// [RL7] pin register reads pins, writes latch
// [RL8] pin writes are read-modify-write into latch
// [RL9] latch holds latest latch or pin write
// [RL10] analog pins read zero, direction still drives
// [RL11] open-drain bit makes output sink only
// [RL12] i2c ownership forces open-drain drive
// [RL13] slew bit limits output slew rate
// [RL14] threshold select governs reads and change detection
// [RL15] software changes thresholds with peripherals off
// [RL16] analog select leaves digital output untouched
// [RL17] analog select resets to analog mode
// [RL18] each pin has selectable weak pull-up
// [RL19] threshold one schmitt, zero ttl
// [RL20] pull-up off whenever pin is output
// [RL21] direction bits reset to input
module gpcc_port
	import gpcc_pkg::*;
(
	input wire logic clk_sys_i, // system clock, 100 MHz
	input wire logic resetn_i, // async reset, active low
	input wire logic psel_i, // apb select
	input wire logic penable_i, // apb enable
	input wire logic pwrite_i, // apb direction
	input wire logic [11:0] paddr_i, // apb byte address
	input wire logic [31:0] pwdata_i, // apb write data
	input wire logic [3:0] pstrb_i, // apb byte strobes
	output logic [31:0] prdata_o, // apb read data
	output logic pready_o, // apb ready
	output logic pslverr_o, // apb error, unmapped
	input wire logic [7:0] pad_st_i, // pad levels, schmitt
	input wire logic [7:0] pad_ttl_i, // pad levels, ttl
	input wire logic [7:0] i2c_own_i, // i2c owns pin
	output logic [7:0] pad_out_o, // pad output level
	output logic [7:0] pad_oe_o, // pad driver enable
	output logic [7:0] pad_pullup_o, // weak pull-up on
	output logic [7:0] pad_slew_o, // slew limited
	output logic [7:0] pad_cc_src_o, // cc source active
	output logic [7:0] pad_cc_snk_o, // cc sink active
	output gpcc_pkg::gpcc_cc_level_t cc_select_o, // regulated current level
	output logic [7:0] pin_level_o // digital input for change detection
);
	import gpcc_pkg::*;

	////////////////////////////////////////////////////////////////
	// declarations
	logic setup; // apb setup cycle
	logic wr_en; // write completes this edge
	logic hit; // mapped address
	logic [7:0] lat_reg, lat_next; // output latch
	logic [7:0] dir_reg, dir_next; // direction bits
	logic [7:0] ans_reg, ans_next; // analog select
	logic [7:0] wpu_reg, wpu_next; // pull-up select
	logic [7:0] odc_reg, odc_next; // open-drain select
	logic [7:0] slr_reg, slr_next; // slew limit select
	logic [7:0] inl_reg, inl_next; // threshold select
	logic [7:0] ccp_reg, ccp_next; // cc source enable bits
	logic [7:0] ccn_reg, ccn_next; // cc sink enable bits
	logic cce_reg, cce_next; // cc global enable
	logic [1:0] ccs_reg, ccs_next; // cc current select
	logic [31:0] rd_reg, rd_next; // read data
	logic err_reg, err_next; // slave error
	logic [7:0] out_c, oe_c, pu_c, slew_c, src_c, snk_c, din_c; // per-pin comb
	logic [7:0] out_reg, oe_reg, pu_reg, slew_reg, src_reg, snk_reg, din_reg; // pad flops

	////////////////////////////////////////////////////////////////
	// apb phase tracker
	gpcc_apb_slave u_apb (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.psel_i(psel_i),
		.penable_i(penable_i),
		.pready_o(pready_o),
		.setup_o(setup)
	);

	assign wr_en = psel_i && penable_i && pready_o && pwrite_i;

	////////////////////////////////////////////////////////////////
	// per-pin logic, one cell per pin
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_pin
			gpcc_pin_cell u_cell ( // RL5
				.lat_i(lat_reg[gi]),
				.dir_i(dir_reg[gi]),
				.ans_i(ans_reg[gi]),
				.wpu_i(wpu_reg[gi]),
				.odc_i(odc_reg[gi]),
				.slr_i(slr_reg[gi]),
				.inl_i(inl_reg[gi]),
				.ccp_i(ccp_reg[gi]),
				.ccn_i(ccn_reg[gi]),
				.cce_i(cce_reg),
				.i2c_i(i2c_own_i[gi]),
				.st_i(pad_st_i[gi]),
				.ttl_i(pad_ttl_i[gi]),
				.out_o(out_c[gi]),
				.oe_o(oe_c[gi]),
				.pu_o(pu_c[gi]),
				.slew_o(slew_c[gi]),
				.src_o(src_c[gi]),
				.snk_o(snk_c[gi]),
				.din_o(din_c[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// register writes, read data and error
	always_comb
	begin
		lat_next = lat_reg;
		dir_next = dir_reg;
		ans_next = ans_reg;
		wpu_next = wpu_reg;
		odc_next = odc_reg;
		slr_next = slr_reg;
		inl_next = inl_reg;
		ccp_next = ccp_reg;
		ccn_next = ccn_reg;
		cce_next = cce_reg;
		ccs_next = ccs_reg;
		rd_next = rd_reg;
		err_next = 1'b0;
		hit = 1'b1;
		case (paddr_i)
			`GPCC_OFF_PINV: rd_next = {24'h000000, din_c}; // RL7 RL10
			`GPCC_OFF_LAT: rd_next = {24'h000000, lat_reg};
			`GPCC_OFF_DIR: rd_next = {24'h000000, dir_reg};
			`GPCC_OFF_ANS: rd_next = {24'h000000, ans_reg};
			`GPCC_OFF_WPU: rd_next = {24'h000000, wpu_reg};
			`GPCC_OFF_ODC: rd_next = {24'h000000, odc_reg};
			`GPCC_OFF_SLR: rd_next = {24'h000000, slr_reg};
			`GPCC_OFF_INL: rd_next = {24'h000000, inl_reg};
			`GPCC_OFF_CCP: rd_next = {24'h000000, ccp_reg};
			`GPCC_OFF_CCN: rd_next = {24'h000000, ccn_reg};
			`GPCC_OFF_CCC: rd_next = {24'h000000, cce_reg, 5'h00, ccs_reg};
			`GPCC_OFF_CCST: rd_next = {16'h0000, snk_reg, src_reg};
			default:
			begin
				rd_next = 32'h00000000; // unmapped reads zero
				hit = 1'b0;
			end
		endcase
		// answer prepared in setup, held through access
		if (!setup)
		begin
			rd_next = rd_reg;
		end
		if (setup)
		begin
			err_next = !hit;
		end
		else if (psel_i && penable_i && !pready_o)
		begin
			err_next = err_reg;
		end
		if (wr_en && pstrb_i[0])
		begin
			case (paddr_i)
				`GPCC_OFF_PINV: lat_next = pwdata_i[7:0]; // RL7 RL9
				`GPCC_OFF_LAT: lat_next = pwdata_i[7:0]; // RL9
				`GPCC_OFF_DIR: dir_next = pwdata_i[7:0];
				`GPCC_OFF_ANS: ans_next = pwdata_i[7:0];
				`GPCC_OFF_WPU: wpu_next = pwdata_i[7:0]; // RL18
				`GPCC_OFF_ODC: odc_next = pwdata_i[7:0];
				`GPCC_OFF_SLR: slr_next = pwdata_i[7:0];
				`GPCC_OFF_INL: inl_next = pwdata_i[7:0];
				`GPCC_OFF_CCP: ccp_next = pwdata_i[7:0];
				`GPCC_OFF_CCN: ccn_next = pwdata_i[7:0];
				`GPCC_OFF_CCC:
				begin
					cce_next = pwdata_i[`GPCC_CCC_EN_BIT];
					ccs_next = pwdata_i[`GPCC_CCC_SEL_HI:`GPCC_CCC_SEL_LO]; // RL2
				end
				default:
				begin
					lat_next = lat_reg; // unmapped or read-only, ignored
				end
			endcase
		end
		else if (wr_en && paddr_i == `GPCC_OFF_PINV)
		begin
			lat_next = din_c; // RL8 unwritten lane keeps the pins read back
		end
	end

	// register file flops
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			lat_reg <= `GPCC_RST_LAT;
			dir_reg <= `GPCC_RST_DIR; // RL21
			ans_reg <= `GPCC_RST_ANS; // RL17
			wpu_reg <= `GPCC_RST_WPU;
			odc_reg <= `GPCC_RST_ODC;
			slr_reg <= `GPCC_RST_SLR;
			inl_reg <= `GPCC_RST_INL;
			ccp_reg <= `GPCC_RST_CCD;
			ccn_reg <= `GPCC_RST_CCD;
			cce_reg <= 1'b0;
			ccs_reg <= `GPCC_RST_CCS;
			rd_reg <= 32'h00000000;
			err_reg <= 1'b0;
		end
		else
		begin
			lat_reg <= lat_next;
			dir_reg <= dir_next;
			ans_reg <= ans_next;
			wpu_reg <= wpu_next;
			odc_reg <= odc_next;
			slr_reg <= slr_next;
			inl_reg <= inl_next;
			ccp_reg <= ccp_next;
			ccn_reg <= ccn_next;
			cce_reg <= cce_next;
			ccs_reg <= ccs_next;
			rd_reg <= rd_next;
			err_reg <= err_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// pad output flops, one cycle after the controls
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			out_reg <= 8'h00;
			oe_reg <= 8'h00;
			pu_reg <= 8'h00;
			slew_reg <= `GPCC_RST_SLR;
			src_reg <= 8'h00;
			snk_reg <= 8'h00;
			din_reg <= 8'h00;
		end
		else
		begin
			out_reg <= out_c;
			oe_reg <= oe_c; // RL6
			pu_reg <= pu_c; // RL20
			slew_reg <= slew_c; // RL13
			src_reg <= src_c; // RL1
			snk_reg <= snk_c; // RL1
			din_reg <= din_c; // RL14
		end
	end

	assign prdata_o = rd_reg;
	assign pslverr_o = err_reg;
	assign pad_out_o = out_reg;
	assign pad_oe_o = oe_reg;
	assign pad_pullup_o = pu_reg;
	assign pad_slew_o = slew_reg;
	assign pad_cc_src_o = src_reg;
	assign pad_cc_snk_o = snk_reg;
	assign cc_select_o = gpcc_cc_level_t'(ccs_reg); // RL2
	assign pin_level_o = din_reg;

	////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	a_cc_gate: assert property ((pad_cc_src_o | pad_cc_snk_o) != 8'h00 |-> $past(cce_reg)) // RL1 RL4
		else $error("cc drive active without global enable");
	a_cc_level: assert property (wr_en && pstrb_i[0] && paddr_i == `GPCC_OFF_CCC // RL2
		|=> cc_select_o == $past(pwdata_i[`GPCC_CCC_SEL_HI:`GPCC_CCC_SEL_LO]))
		else $error("current select does not follow control");
	a_oe_dir: assert property ((pad_oe_o & $past(dir_reg)) == 8'h00) // RL6
		else $error("driver on for input pin");
	a_pinv_write: assert property (wr_en && pstrb_i[0] && paddr_i == `GPCC_OFF_PINV
		|=> lat_reg == $past(pwdata_i[7:0]) ##1 pad_out_o == $past(pwdata_i[7:0], 2)) // RL7 RL9
		else $error("pin register write did not reach latch");
	a_rmw_write: assert property (wr_en && !pstrb_i[0] && paddr_i == `GPCC_OFF_PINV
		|=> lat_reg == $past(din_c)) // RL8
		else $error("read-modify-write lost pin values");
	a_analog_zero: assert property ((pin_level_o & $past(ans_reg)) == 8'h00) // RL10
		else $error("analog pin reads nonzero");
	a_od_sink: assert property ((pad_oe_o & pad_out_o & $past(odc_reg | i2c_own_i)) == 8'h00) // RL11 RL12
		else $error("open-drain pin sourced current");
	a_slew_follow: assert property (pad_slew_o == $past(slr_reg)) // RL13
		else $error("slew control mismatch");
	a_thresh_sel: assert property (pin_level_o ==
		$past(~ans_reg & ((inl_reg & pad_st_i) | (~inl_reg & pad_ttl_i)))) // RL14 RL19
		else $error("wrong input threshold used");
	a_pullup_out: assert property ((pad_pullup_o & ~$past(dir_reg)) == 8'h00) // RL20
		else $error("pull-up on for output pin");
	a_reset_vals: assert property ($rose(resetn_i) |-> dir_reg == `GPCC_RST_DIR && ans_reg == `GPCC_RST_ANS) // RL17 RL21
		else $error("direction or analog select wrong after reset");

	c_cc_on: cover property (cce_reg && pad_cc_src_o != 8'h00);
	c_pinv_wr: cover property (wr_en && paddr_i == `GPCC_OFF_PINV);
	c_od_drive: cover property ((pad_oe_o & ~pad_out_o) != 8'h00 && odc_reg != 8'h00);
	c_unmapped: cover property (pslverr_o && pready_o);
endmodule
`default_nettype wire

// ### gpcc_cfg.svh
// gpcc_cfg.svh: register offsets, reset values and field positions
// assumes a 32-bit apb bus with word-aligned byte addresses
`ifndef GPCC_CFG_SVH
`define GPCC_CFG_SVH

// byte offsets of the register words
`define GPCC_OFF_PINV 12'h000
`define GPCC_OFF_LAT 12'h004
`define GPCC_OFF_DIR 12'h008
`define GPCC_OFF_ANS 12'h00c
`define GPCC_OFF_WPU 12'h010
`define GPCC_OFF_ODC 12'h014
`define GPCC_OFF_SLR 12'h018
`define GPCC_OFF_INL 12'h01c
`define GPCC_OFF_CCP 12'h020
`define GPCC_OFF_CCN 12'h024
`define GPCC_OFF_CCC 12'h028
`define GPCC_OFF_CCST 12'h02c

// reset values
`define GPCC_RST_LAT 8'h00
`define GPCC_RST_DIR 8'hff
`define GPCC_RST_ANS 8'hff
`define GPCC_RST_WPU 8'h00
`define GPCC_RST_ODC 8'h00
`define GPCC_RST_SLR 8'hff
`define GPCC_RST_INL 8'hff
`define GPCC_RST_CCD 8'h00
`define GPCC_RST_CCS 2'h0

// cc_control fields
`define GPCC_CCC_EN_BIT 7
`define GPCC_CCC_SEL_HI 1
`define GPCC_CCC_SEL_LO 0

`endif

// ### gpcc_pkg.sv
// gpcc_pkg.sv: types shared by the port block
// assumes nothing beyond the compiler
package gpcc_pkg;
	// apb slave phase
	typedef enum logic [0:0] {
		GPCC_IDLE = 1'b0,
		GPCC_ACCESS = 1'b1
	} gpcc_apb_st_t;
	// regulated current codes
	typedef enum logic [1:0] {
		GPCC_CC_10MA = 2'b00,
		GPCC_CC_5MA = 2'b01,
		GPCC_CC_2MA = 2'b10,
		GPCC_CC_1MA = 2'b11
	} gpcc_cc_level_t;
endpackage

// ### gpcc_apb_slave.sv
// gpcc_apb_slave.sv: apb phase tracker, registered zero-wait answer
// assumes the master keeps the request stable until pready is seen
`timescale 1ns/1ps
`default_nettype none
module gpcc_apb_slave
	import gpcc_pkg::*;
(
	input wire logic clk_sys_i, // system clock
	input wire logic resetn_i, // async reset, active low
	input wire logic psel_i, // select
	input wire logic penable_i, // access phase
	output logic pready_o, // answer, from flop
	output logic setup_o // setup cycle seen
);
	gpcc_apb_st_t st_reg; // current phase
	gpcc_apb_st_t st_next; // next phase
	logic rdy_reg; // pready flop
	logic rdy_next; // pready next

	////////////////////////////////////////////////////////////////
	// next phase: answer in the first access cycle
	always_comb
	begin
		st_next = st_reg;
		rdy_next = 1'b0;
		case (st_reg)
			GPCC_IDLE:
			begin
				if (psel_i && !penable_i)
				begin
					st_next = GPCC_ACCESS;
					rdy_next = 1'b1;
				end
			end
			GPCC_ACCESS:
			begin
				st_next = GPCC_IDLE; // transfer completes here
			end
			default:
			begin
				st_next = GPCC_IDLE;
			end
		endcase
	end

	// phase registers
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			st_reg <= GPCC_IDLE;
			rdy_reg <= 1'b0;
		end
		else
		begin
			st_reg <= st_next;
			rdy_reg <= rdy_next;
		end
	end

	assign pready_o = rdy_reg;
	assign setup_o = (st_reg == GPCC_IDLE) && psel_i && !penable_i;
endmodule
`default_nettype wire

// ### gpcc_pin_cell.sv
// gpcc_pin_cell.sv: drive and input path of one port pin
// assumes pad levels synchronous to the system clock
`timescale 1ns/1ps
`default_nettype none
module gpcc_pin_cell (
	input wire logic lat_i, // output latch bit
	input wire logic dir_i, // 1 input, 0 output
	input wire logic ans_i, // analog select
	input wire logic wpu_i, // pull-up select
	input wire logic odc_i, // open-drain select
	input wire logic slr_i, // slew limit select
	input wire logic inl_i, // 1 schmitt, 0 ttl
	input wire logic ccp_i, // cc source enable
	input wire logic ccn_i, // cc sink enable
	input wire logic cce_i, // cc global enable
	input wire logic i2c_i, // i2c owns pin
	input wire logic st_i, // schmitt pad level
	input wire logic ttl_i, // ttl pad level
	output logic out_o, // driven level
	output logic oe_o, // driver enable
	output logic pu_o, // pull-up on
	output logic slew_o, // slew limited
	output logic src_o, // cc source active
	output logic snk_o, // cc sink active
	output logic din_o // digital input
);
	logic od; // open-drain in force

	// drive: analog select does not touch the output path
	always_comb
	begin
		od = odc_i | i2c_i; // RL12
		out_o = lat_i;
		oe_o = !dir_i && (!od || !lat_i); // RL6 RL11 RL16
		pu_o = wpu_i && dir_i; // RL18 RL20
		slew_o = slr_i; // RL13
		src_o = ccp_i && cce_i; // RL1 RL4
		snk_o = ccn_i && cce_i; // RL1 RL4
		din_o = ans_i ? 1'b0 : (inl_i ? st_i : ttl_i); // RL10 RL14 RL19
	end
endmodule
`default_nettype wire

// ### gpcc_pad_model.sv
// gpcc_pad_model.sv: external circuitry seen by the eight port pads
// assumes pad controls registered on clk_sys_i
`timescale 1ns/1ps
`default_nettype none
module gpcc_pad_model (
	input wire logic clk_sys_i, // system clock
	input wire logic [7:0] out_i, // device drive level
	input wire logic [7:0] oe_i, // device driver on
	input wire logic [7:0] pu_i, // device pull-up on
	input wire logic [7:0] ext_i, // external level
	input wire logic [7:0] ext_en_i, // external drive on, weaker than device
	input wire logic [7:0] skew_i, // pins where ttl sees the inverse
	output logic [7:0] st_o, // schmitt receiver level
	output logic [7:0] ttl_o // ttl receiver level
);
	logic [7:0] flt_reg = 8'h5a; // wander of undriven lines
	logic [7:0] lvl; // resolved wire level
	////////////////////////////////////////////////////////////
	// undriven, unpulled lines change every cycle
	always @(posedge clk_sys_i)
	begin
		flt_reg <= ~flt_reg;
	end
	// device driver wins, then external, then pull-up
	always_comb
	begin
		lvl = (oe_i & out_i) | (~oe_i & ext_en_i & ext_i) | (~oe_i & ~ext_en_i & (pu_i | flt_reg));
		st_o = lvl;
		ttl_o = lvl ^ skew_i;
	end
endmodule
`default_nettype wire

// ### gpcc_port_tb.sv
// gpcc_port_tb.sv: self-checking bench of the port block
// assumes gpcc_port, gpcc_pad_model and the cfg header
`timescale 1ns/1ps
`default_nettype none
`include "gpcc_cfg.svh"
module gpcc_port_tb;
	import gpcc_pkg::*;
	logic clk, rstn, psel, pen, pwr, prdy, perr; // clock, reset, apb
	logic [11:0] pa; // apb address
	logic [31:0] pwd, prd; // apb data
	logic [3:0] ps; // apb strobes
	logic [7:0] st, ttl, i2c, pout, poe, ppu, pslw, psrc, psnk, plvl; // pads
	logic [7:0] ext, exten, skew; // far side stimulus
	gpcc_cc_level_t csel; // current code out
	logic [7:0] v [0:10]; // register shadow by word index
	int fails, n_compared; // counters
	gpcc_port dut (.clk_sys_i(clk), .resetn_i(rstn), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(pa), .pwdata_i(pwd), .pstrb_i(ps), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
		.pad_st_i(st), .pad_ttl_i(ttl), .i2c_own_i(i2c), .pad_out_o(pout), .pad_oe_o(poe),
		.pad_pullup_o(ppu), .pad_slew_o(pslw), .pad_cc_src_o(psrc), .pad_cc_snk_o(psnk),
		.cc_select_o(csel), .pin_level_o(plvl));
	gpcc_pad_model pads (.clk_sys_i(clk), .out_i(pout), .oe_i(poe), .pu_i(ppu), .ext_i(ext),
		.ext_en_i(exten), .skew_i(skew), .st_o(st), .ttl_o(ttl));
	////////////////////////////////////////////////////////////
	// expected pad behaviour
	function automatic logic [7:0] f_oe();
		return ~v[2] & (~(v[5] | i2c) | ~v[1]);
	endfunction
	function automatic logic [7:0] f_pu();
		return v[4] & v[2];
	endfunction
	function automatic logic [7:0] f_lv();
		return (f_oe() & v[1]) | (~f_oe() & exten & ext) | (~f_oe() & ~exten & f_pu());
	endfunction
	function automatic logic [7:0] f_pin();
		return ~v[3] & (f_lv() ^ (skew & ~v[7]));
	endfunction
	////////////////////////////////////////////////////////////
	// compare and verdict
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			fails++;
			$display("ERROR %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic stop_test();
		if (fails == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// one apb transfer, entered and left just after a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		ps <= s;
		@(posedge clk);
		pen <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (prdy !== 1'b1);
		cmp(32'(n), 32'h1);
		r = prd;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, s, r, e);
	endtask
	// full configuration from the shadow
	task automatic cfg();
		wr(`GPCC_OFF_CCP, 32'h0, 4'h1);
		wr(`GPCC_OFF_CCN, 32'h0, 4'h1);
		wr(`GPCC_OFF_CCC, 32'(v[10]), 4'h1);
		for (int i = 1; i < 10; i++)
			wr(12'(4 * i), 32'(v[i]), 4'h1);
	endtask
	// pads, register readback, pin value, status
	task automatic chk();
		logic [31:0] r;
		logic e;
		logic [7:0] k, en;
		k = f_oe() | exten | f_pu();
		en = {8{v[10][7]}};
		repeat (4) @(posedge clk);
		#1;
		cmp(32'(poe), 32'(f_oe()));
		cmp(32'(pout), 32'(v[1]));
		cmp(32'(ppu), 32'(f_pu()));
		cmp(32'(pslw), 32'(v[6]));
		cmp(32'(psrc), 32'(v[8] & en));
		cmp(32'(psnk), 32'(v[9] & en));
		cmp(32'(csel), 32'(v[10][1:0]));
		cmp(32'(plvl & k), 32'(f_pin() & k));
		@(posedge clk);
		for (int i = 1; i < 11; i++)
		begin
			apb(1'b0, 12'(4 * i), 32'h0, 4'h0, r, e);
			cmp(r, 32'(v[i] & (i == 10 ? 8'h83 : 8'hff)));
		end
		apb(1'b0, `GPCC_OFF_PINV, 32'h0, 4'h0, r, e);
		cmp(r & 32'(k), 32'(f_pin() & k));
		apb(1'b0, `GPCC_OFF_CCST, 32'h0, 4'h0, r, e);
		cmp(r, {16'h0, v[9] & en, v[8] & en});
	endtask
	// reset pulse, pad levels during it, reset values after
	task automatic rst();
		rstn <= 1'b0;
		exten <= 8'hff;
		i2c <= 8'h00;
		repeat (9) @(posedge clk);
		#1;
		cmp(32'(pslw), 32'hff);
		cmp(32'(poe), 32'h0);
		@(posedge clk);
		rstn <= 1'b1;
		v = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
		chk();
	endtask
	////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		repeat (30000) @(posedge clk);
		cmp(32'h1, 32'h0);
		stop_test();
	end
	// main sequence
	initial
	begin
		logic [31:0] d, r;
		logic e;
		logic [3:0] s;
		{rstn, psel, pen, pwr, pa, pwd, ps} = '0;
		{i2c, ext, skew, exten} = '0;
		fails = 0;
		n_compared = 0;
		void'($urandom(32'h0b038b66));
		rst();
		for (int it = 0; it < 40; it++)
		begin
			for (int i = 1; i < 11; i++)
				v[i] = 8'($urandom);
			v[10][1:0] = it[1:0];
			if (it == 0)
			begin
				v[2] = 8'h00;
				v[5] = 8'h0f;
				v[10][7] = 1'b1;
			end
			if (!v[10][7])
				{v[8], v[9]} = 16'h0;
			i2c <= 8'($urandom);
			ext <= 8'($urandom);
			skew <= 8'($urandom);
			exten <= it[0] ? 8'($urandom) : 8'hff;
			cfg();
			wr(`GPCC_OFF_LAT, 32'(~v[1]), 4'h2);
			chk();
			s = it[0] ? 4'h1 : 4'h0;
			d = $urandom;
			wr(`GPCC_OFF_PINV, d, s);
			v[1] = s[0] ? d[7:0] : f_pin();
			chk();
		end
		apb(1'b0, 12'h030, 32'h0, 4'h0, r, e);
		cmp({31'h0, e}, 32'h1);
		cmp(r, 32'h0);
		apb(1'b1, 12'h030, 32'hff, 4'hf, r, e);
		cmp({31'h0, e}, 32'h1);
		wr(`GPCC_OFF_CCST, 32'hffff, 4'hf);
		chk();
		rst();
		stop_test();
	end
endmodule
`default_nettype wire
